/* File: verilog/trigger_io_pin.sv */
// Top of the trigger I/O pin: AXI4-Lite registers, function select and pin drive.
// ****************************************************************
// ****************************************************************
`default_nettype none
module trigger_io_pin #(
   parameter int MIN_LOW_CYC = trig_pin_pkg::LOW_MIN_CYC,
   parameter int PWM_W = 32
) (
   input wire logic clock, // 40 MHz system clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic [7:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [7:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic pin_in, // Pin level seen at the connector.
   output logic pin_out, // Level driven onto the pin.
   output logic pin_oe, // High while the block drives the pin.
   input wire logic internal_trigger, // One-cycle pulse: device made a trigger.
   input wire logic panel_trigger, // One-cycle pulse: front-panel trigger key.
   output logic meter_start, // One-cycle pulse: start metering.
   output logic dlog_start, // One-cycle pulse: start data recording.
   output logic seq_start // One-cycle pulse: start sequence run.
);
   import trig_pin_pkg::*;

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [1:0] func_reg;
   logic invert_reg;
   logic dir_out_reg;
   logic [1:0] target_reg;
   logic [1:0] level_reg;
   logic seq_ext_reg;
   logic [PWM_W-1:0] period_reg;
   logic [PWM_W-1:0] duty_reg;
   logic armed_reg;
   logic in_level_reg;
   logic pin_out_reg;
   logic pin_oe_reg;
   logic meter_start_reg;
   logic dlog_start_reg;
   logic seq_start_reg;

   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   logic wr_go;
   logic ar_go;
   logic qualified;
   logic pulse_low;
   logic emit_busy;
   logic pwm_wave;
   logic level_adj;
   logic cmd_arm;
   logic cmd_disarm;

   // Merge byte strobes into an old word.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Decode whether a byte address maps to a register.
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == ADDR_CTRL) || (a == ADDR_PWM_PERIOD) || (a == ADDR_PWM_DUTY) ||
         (a == ADDR_STATUS) || (a == ADDR_COMMAND);
   endfunction

   // ****************************************************************
   // AXI4-Lite write path
   // ****************************************************************
   // Address and data are caught independently, so either may come first.
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;

   always_ff @(posedge clock) begin
      if (srst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer SLVERR.
   always_ff @(posedge clock) begin
      if (srst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= AXI_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= is_mapped(awaddr_reg) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // Control register; an unknown function code is refused to keep one mode.
   always_ff @(posedge clock) begin
      if (srst) begin
         func_reg <= FUNC_TRIGGER;
         invert_reg <= 1'b0;
         dir_out_reg <= 1'b0;
         target_reg <= TGT_SEQ;
         level_reg <= LVL_ZERO;
         seq_ext_reg <= 1'b0;
      end else if (wr_go && awaddr_reg == ADDR_CTRL) begin
         logic [31:0] v;
         v = merge({23'h0, seq_ext_reg, level_reg, target_reg, dir_out_reg, invert_reg,
                    func_reg}, wdata_reg, wstrb_reg);
         if (v[CTRL_FUNC_LSB +: 2] != 2'h3) begin
            func_reg <= v[CTRL_FUNC_LSB +: 2];
         end
         invert_reg <= v[CTRL_INVERT_BIT];
         dir_out_reg <= v[CTRL_DIR_BIT];
         if (v[CTRL_TARGET_LSB +: 2] != 2'h3) begin
            target_reg <= v[CTRL_TARGET_LSB +: 2];
         end
         if (v[CTRL_LEVEL_LSB +: 2] != 2'h3) begin
            level_reg <= v[CTRL_LEVEL_LSB +: 2];
         end
         seq_ext_reg <= v[CTRL_SEQSRC_BIT];
      end
   end

   // PWM period and duty registers.
   always_ff @(posedge clock) begin
      if (srst) begin
         period_reg <= PWM_W'(PWM_PERIOD_RST);
         duty_reg <= PWM_W'(PWM_DUTY_RST);
      end else if (wr_go && awaddr_reg == ADDR_PWM_PERIOD) begin
         period_reg <= PWM_W'(merge(32'(period_reg), wdata_reg, wstrb_reg));
      end else if (wr_go && awaddr_reg == ADDR_PWM_DUTY) begin
         duty_reg <= PWM_W'(merge(32'(duty_reg), wdata_reg, wstrb_reg));
      end
   end

   assign cmd_arm = wr_go && awaddr_reg == ADDR_COMMAND && wstrb_reg[0] &&
      wdata_reg[CMD_ARM_BIT];
   assign cmd_disarm = wr_go && awaddr_reg == ADDR_COMMAND && wstrb_reg[0] &&
      wdata_reg[CMD_DISARM_BIT];

   // ****************************************************************
   // AXI4-Lite read path
   // ****************************************************************
   assign s_axi_arready = !rvalid_reg;
   assign ar_go = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge clock) begin
      if (srst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= AXI_OKAY;
      end else if (ar_go) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= is_mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
         case (s_axi_araddr)
            ADDR_CTRL: rdata_reg <= {23'h0, seq_ext_reg, level_reg, target_reg, dir_out_reg,
                                    invert_reg, func_reg};
            ADDR_PWM_PERIOD: rdata_reg <= 32'(period_reg);
            ADDR_PWM_DUTY: rdata_reg <= 32'(duty_reg);
            ADDR_STATUS: rdata_reg <= {29'h0, emit_busy, armed_reg, in_level_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ****************************************************************
   // Pin logic
   // ****************************************************************
   // Invert applies before qualification, so a high-going pulse works when inverted.
   assign level_adj = pin_in ^ invert_reg;

   low_pulse_qualifier #(
      .MIN_CYC(MIN_LOW_CYC)
   ) u_qual (
      .clock(clock),
      .srst(srst),
      .level_in(level_adj),
      .fire(func_reg == FUNC_TRIGGER && dir_out_reg && internal_trigger),
      .qualified(qualified),
      .pulse_low(pulse_low),
      .emit_busy(emit_busy)
   );

   pwm_gen #(
      .W(PWM_W)
   ) u_pwm (
      .clock(clock),
      .srst(srst),
      .period(period_reg),
      .duty(duty_reg),
      .wave(pwm_wave)
   );

   // Sampled level for the input function; other modes still show the pin.
   always_ff @(posedge clock) begin
      if (srst) begin
         in_level_reg <= 1'b0;
      end else begin
         in_level_reg <= level_adj;
      end
   end

   // Arm flag: the set wins over a disarm; a meter start consumes it.
   always_ff @(posedge clock) begin
      if (srst) begin
         armed_reg <= 1'b0;
      end else if (cmd_arm) begin
         armed_reg <= 1'b1;
      end else if (cmd_disarm || meter_start_reg) begin
         armed_reg <= 1'b0;
      end
   end

   // Start pulses toward the instrument functions.
   always_ff @(posedge clock) begin
      if (srst) begin
         meter_start_reg <= 1'b0;
         dlog_start_reg <= 1'b0;
         seq_start_reg <= 1'b0;
      end else begin
         logic trig_in;
         trig_in = func_reg == FUNC_TRIGGER && !dir_out_reg && qualified;
         meter_start_reg <= trig_in && target_reg == TGT_METER && armed_reg;
         dlog_start_reg <= trig_in && target_reg == TGT_DLOG;
         seq_start_reg <= seq_ext_reg ? (trig_in && target_reg == TGT_SEQ) :
            panel_trigger;
      end
   end

   assign meter_start = meter_start_reg;
   assign dlog_start = dlog_start_reg;
   assign seq_start = seq_start_reg;

   // Pin drive per function; in trigger-out use the line idles high (inactive), or low when invert is set.
   always_ff @(posedge clock) begin
      if (srst) begin
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         case (func_reg)
            FUNC_TRIGGER: begin
               pin_oe_reg <= dir_out_reg;
               pin_out_reg <= (!pulse_low) ^ invert_reg;
            end
            FUNC_OUTPUT: begin
               pin_oe_reg <= 1'b1;
               case (level_reg)
                  LVL_ONE: pin_out_reg <= 1'b1 ^ invert_reg;
                  LVL_PWM: pin_out_reg <= pwm_wave ^ invert_reg;
                  default: pin_out_reg <= 1'b0 ^ invert_reg;
               endcase
            end
            default: begin
               pin_oe_reg <= 1'b0;
               pin_out_reg <= 1'b0;
            end
         endcase
      end
   end

   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;
endmodule
`default_nettype wire

/* File: verilog/trig_pin_pkg.sv */
// Constants, register map and mode encodings of the trigger I/O pin block.
`default_nettype none
package trig_pin_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLOCK_HZ = 40_000_000;
   localparam int LOW_MIN_US = 30;
   // Least time in whole cycles, never below 1; the cycles-per-microsecond figure is truncated.
   localparam int LOW_MIN_CYC = (LOW_MIN_US * (CLOCK_HZ / 1_000_000) + 0) < 1 ? 1 :
      LOW_MIN_US * (CLOCK_HZ / 1_000_000);
   localparam int CNT_W = 16;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PWM_PERIOD = 8'h04;
   localparam logic [7:0] ADDR_PWM_DUTY = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_COMMAND = 8'h10;

   // CTRL fields.
   localparam int CTRL_FUNC_LSB = 0;
   localparam int CTRL_INVERT_BIT = 2;
   localparam int CTRL_DIR_BIT = 3;
   localparam int CTRL_TARGET_LSB = 4;
   localparam int CTRL_LEVEL_LSB = 6;
   localparam int CTRL_SEQSRC_BIT = 8;
   // STATUS fields.
   localparam int STAT_LEVEL_BIT = 0;
   localparam int STAT_ARMED_BIT = 1;
   localparam int STAT_BUSY_BIT = 2;
   // COMMAND fields.
   localparam int CMD_ARM_BIT = 0;
   localparam int CMD_DISARM_BIT = 1;

   localparam logic [31:0] PWM_PERIOD_RST = 32'h0000_9C40;
   localparam logic [31:0] PWM_DUTY_RST = 32'h0000_4E20;

   typedef enum logic [1:0] {
      FUNC_TRIGGER = 2'h0,
      FUNC_INPUT = 2'h1,
      FUNC_OUTPUT = 2'h2
   } pin_func_t;

   typedef enum logic [1:0] {
      TGT_METER = 2'h0,
      TGT_DLOG = 2'h1,
      TGT_SEQ = 2'h2
   } trig_target_t;

   typedef enum logic [1:0] {
      LVL_ZERO = 2'h0,
      LVL_ONE = 2'h1,
      LVL_PWM = 2'h2
   } out_level_t;

   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: verilog/low_pulse_qualifier.sv */
// Low-pulse width qualifier and pulse generator for the trigger pin.
`default_nettype none
module low_pulse_qualifier #(
   parameter int MIN_CYC = trig_pin_pkg::LOW_MIN_CYC
) (
   input wire logic clock, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic level_in, // Polarity-adjusted pin level.
   input wire logic fire, // Request to emit a low pulse.
   output logic qualified, // One-cycle pulse on a qualified low interval.
   output logic pulse_low, // High while the emitted low pulse lasts.
   output logic emit_busy // Emitter still busy.
);
   import trig_pin_pkg::*;

   logic [CNT_W-1:0] low_cnt_reg;
   logic [CNT_W-1:0] emit_cnt_reg;
   logic seen_reg;
   logic qual_reg;

   // Count how long the line stays low; a short glitch resets the count.
   always_ff @(posedge clock) begin
      if (srst || level_in) begin
         low_cnt_reg <= '0;
         seen_reg <= 1'b0;
         qual_reg <= 1'b0;
      end else begin
         qual_reg <= 1'b0;
         if (!seen_reg) begin
            if (low_cnt_reg == CNT_W'(MIN_CYC - 1)) begin
               seen_reg <= 1'b1;
               qual_reg <= 1'b1;
            end else begin
               low_cnt_reg <= low_cnt_reg + 1'b1;
            end
         end
      end
   end

   // Emit a low pulse of exactly the least width; a fire while busy is dropped.
   always_ff @(posedge clock) begin
      if (srst) begin
         emit_cnt_reg <= '0;
      end else if (emit_cnt_reg != '0) begin
         emit_cnt_reg <= emit_cnt_reg - 1'b1;
      end else if (fire) begin
         emit_cnt_reg <= CNT_W'(MIN_CYC);
      end
   end

   assign qualified = qual_reg;
   assign pulse_low = (emit_cnt_reg != '0);
   assign emit_busy = pulse_low;
endmodule
`default_nettype wire

/* File: verilog/pwm_gen.sv */
// Programmable PWM waveform generator.
`default_nettype none
module pwm_gen #(
   parameter int W = 32
) (
   input wire logic clock, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic [W-1:0] period, // Period in clock cycles.
   input wire logic [W-1:0] duty, // High time in clock cycles.
   output logic wave // PWM output, registered.
);
   logic [W-1:0] cnt_reg;
   logic wave_reg;

   // Free-running period counter; a zero period holds the output low.
   always_ff @(posedge clock) begin
      if (srst || period == '0) begin
         cnt_reg <= '0;
         wave_reg <= 1'b0;
      end else begin
         cnt_reg <= (cnt_reg >= period - 1'b1) ? '0 : cnt_reg + 1'b1;
         wave_reg <= (cnt_reg < duty);
      end
   end

   assign wave = wave_reg;
endmodule
`default_nettype wire

/* File: tb/trig_partner.sv */
// Model of the external instrument that sends and watches trigger pulses.
`default_nettype none
module trig_partner (
   input wire logic clock, // System clock.
   input wire logic pin, // Resolved pin level.
   input wire logic block_oe, // High while the block drives the pin.
   output logic drv_oe, // High while this model drives the pin.
   output logic drv_lvl, // Level this model drives.
   output int low_len // Length of the last low pulse the block emitted.
);
   timeunit 1ns;
   timeprecision 1ns;
   int run;
   initial begin
      drv_oe = 1'b0;
      drv_lvl = 1'b1;
      low_len = 0;
      run = 0;
   end
   // Measure each low interval the block drives; the width is latched when it ends.
   always @(posedge clock) begin
      if (block_oe && !pin) begin
         run <= run + 1;
      end else if (run != 0) begin
         low_len <= run;
         run <= 0;
      end
   end
   // Drive a level for some cycles, then settle at the idle level and keep driving it.
   task automatic drive(input logic lvl, input int cyc, input logic idle);
      drv_oe <= 1'b1;
      drv_lvl <= lvl;
      repeat (cyc) @(posedge clock);
      drv_lvl <= idle;
   endtask
   // Let go of the line; the pull-up then holds it high.
   task automatic let_go();
      drv_oe <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/trigger_io_pin_props.sv */
// Checker of the trigger I/O pin block's port behaviour.
`default_nettype none
module trigger_io_pin_props #(
   parameter int MIN_LOW_CYC = 1200
) (
   input wire logic clock, // System clock.
   input wire logic srst, // Synchronous reset.
   input wire logic s_axi_awvalid, // Write address valid.
   input wire logic s_axi_awready, // Write address ready.
   input wire logic s_axi_wvalid, // Write data valid.
   input wire logic s_axi_wready, // Write data ready.
   input wire logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic s_axi_arvalid, // Read address valid.
   input wire logic s_axi_arready, // Read address ready.
   input wire logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic pin_in, // Pin level.
   input wire logic pin_out, // Driven level.
   input wire logic pin_oe, // Drive enable.
   input wire logic internal_trigger, // Device trigger.
   input wire logic meter_start, // Meter start.
   input wire logic dlog_start, // Logging start.
   input wire logic seq_start // Sequence start.
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   logic pin_last_reg;
   int run_reg;
   // Count cycles the pin has kept one level; polarity-blind so invert needs no tracking.
   always_ff @(posedge clock) begin
      pin_last_reg <= pin_in;
      run_reg <= (pin_in == pin_last_reg) ? run_reg + 1 : 0;
   end
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence out_launch;
      internal_trigger ##[1:3] (pin_oe && $changed(pin_out));
   endsequence
   AST_ONE_TARGET: assert property ($onehot0({meter_start, dlog_start, seq_start}))
      else $error("two starts at once");
   AST_DLOG_QUAL: assert property (dlog_start |-> ($past(run_reg) >= MIN_LOW_CYC - 2 ||
      $past(run_reg, 2) >= MIN_LOW_CYC - 2 || $past(run_reg, 3) >= MIN_LOW_CYC - 2))
      else $error("logging started by a short pulse");
   AST_OUT_WIDTH: assert property (out_launch |=> $stable(pin_out) [*2])
      else $error("emitted pulse too short");
   AST_RESET_IDLE: assert property ($fell(srst) |-> !pin_oe && !meter_start && !seq_start)
      else $error("not idle after reset");
   AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_WR_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
      else $error("write response repeated");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
endmodule
bind trigger_io_pin trigger_io_pin_props #(.MIN_LOW_CYC(MIN_LOW_CYC)) chk (.clock, .srst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pin_in,
   .pin_out, .pin_oe, .internal_trigger, .meter_start, .dlog_start, .seq_start);
`default_nettype wire

/* File: tb/trigger_io_pin_test.sv */
// Self-checking bench of the trigger I/O pin block.
`default_nettype none
module trigger_io_pin_test;
   timeunit 1ns;
   timeprecision 100ps;
   import trig_pin_pkg::*;
   localparam int MINC = 4;
   logic clock = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, internal_trigger = 0, panel_trigger = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_in;
   logic pin_out, pin_oe, meter_start, dlog_start, seq_start, p_oe, p_lvl;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int err_count = 0, cmp_count = 0, cyc = 0, meter_n = 0, dlog_n = 0, seq_n = 0, hi;
   int low_len;
   trigger_io_pin #(.MIN_LOW_CYC(MINC)) uut (.clock, .srst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
      .internal_trigger, .panel_trigger, .meter_start, .dlog_start, .seq_start);
   trig_partner far (.clock, .pin(pin_in), .block_oe(pin_oe), .drv_oe(p_oe), .drv_lvl(p_lvl),
      .low_len);
   // The line has a pull-up, so it reads high when nobody drives it.
   assign pin_in = pin_oe ? pin_out : (p_oe ? p_lvl : 1'b1);
   initial begin
      forever #12.5 clock = ~clock;
   end
   // Count start pulses and cycles; a run far past its expected length counts as a hang.
   always @(posedge clock) begin
      meter_n <= meter_n + int'(meter_start);
      dlog_n <= dlog_n + int'(dlog_start);
      seq_n <= seq_n + int'(seq_start);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Bus tasks start just after an edge and hold each channel until it is taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      logic aw_done, w_done, b_done;
      {aw_done, w_done, b_done} = 3'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= dat;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!b_done) begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready && !aw_done) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready && !w_done) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) begin
            b_done = 1'b1;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
      // One spare edge, so a following call never drives a signal twice in one step.
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask
   // The start answer follows qualification by one cycle; a few spare cycles cover it.
   task automatic settle();
      repeat (MINC + 6) @(posedge clock);
   endtask
   task automatic pin_pulse(input logic lvl, input int w, input logic idle);
      far.drive(lvl, w, idle);
      settle();
   endtask
   task automatic panel();
      panel_trigger <= 1'b1;
      @(posedge clock);
      panel_trigger <= 1'b0;
      settle();
   endtask
   task automatic t_reset();
      rd(ADDR_CTRL);
      chk(d, 32'h0000_0020);
      rd(ADDR_PWM_PERIOD);
      chk(d, PWM_PERIOD_RST);
      rd(8'h14);
      chk(d, 32'h0000_0000);
      chk({30'h0, r}, {30'h0, AXI_SLVERR});
      wr(8'h14, 32'h0000_0001);
      chk({30'h0, r}, {30'h0, AXI_SLVERR});
      $display("test reset done");
   endtask
   task automatic t_seq();
      wr(ADDR_CTRL, 32'h0000_0120);
      chk({30'h0, r}, {30'h0, AXI_OKAY});
      pin_pulse(1'b0, MINC - 2, 1'b1);
      chk(seq_n, 0);
      pin_pulse(1'b0, MINC, 1'b1);
      chk(seq_n, 1);
      panel();
      chk(seq_n, 1);
      wr(ADDR_CTRL, 32'h0000_0020);
      pin_pulse(1'b0, MINC, 1'b1);
      chk(seq_n, 1);
      panel();
      chk(seq_n, 2);
      $display("test sequence done");
   endtask
   task automatic t_meter();
      wr(ADDR_CTRL, 32'h0000_0000);
      pin_pulse(1'b0, MINC, 1'b1);
      chk(meter_n, 0);
      wr(ADDR_COMMAND, 32'h0000_0001);
      rd(ADDR_STATUS);
      chk(d & 32'h2, 32'h2);
      pin_pulse(1'b0, MINC, 1'b1);
      chk(meter_n, 1);
      pin_pulse(1'b0, MINC, 1'b1);
      chk(meter_n, 1);
      wr(ADDR_COMMAND, 32'h0000_0001);
      wr(ADDR_COMMAND, 32'h0000_0002);
      rd(ADDR_STATUS);
      chk(d & 32'h2, 32'h0);
      pin_pulse(1'b0, MINC, 1'b1);
      chk(meter_n, 1);
      far.let_go();
      $display("test meter done");
   endtask
   task automatic t_out();
      wr(ADDR_CTRL, 32'h0000_0008);
      internal_trigger <= 1'b1;
      @(posedge clock);
      internal_trigger <= 1'b0;
      settle();
      chk(low_len, MINC);
      chk({31'h0, pin_oe}, 32'h1);
      $display("test trigger out done");
   endtask
   task automatic t_gpo();
      logic [31:0] ctl[4] = '{32'h42, 32'h02, 32'h46, 32'h06};
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CTRL, ctl[i]);
         repeat (2) @(posedge clock);
         chk({pin_oe, pin_out}, {1'b1, ctl[i][6] ^ ctl[i][2]});
      end
      wr(ADDR_PWM_PERIOD, 32'h4);
      wr(ADDR_PWM_DUTY, 32'h1);
      wr(ADDR_CTRL, 32'h82);
      hi = 0;
      repeat (4) @(posedge clock);
      repeat (8) begin
         @(posedge clock);
         hi += int'(pin_out);
      end
      chk(hi, 2);
      $display("test output done");
   endtask
   task automatic t_inv();
      wr(ADDR_CTRL, 32'h0000_0001);
      far.drive(1'b0, 1, 1'b0);
      wr(ADDR_CTRL, 32'h0000_0014);
      pin_pulse(1'b1, MINC, 1'b0);
      chk(dlog_n, 1);
      wr(ADDR_CTRL, 32'h0000_0001);
      rd(ADDR_STATUS);
      chk(d & 32'h1, 32'h0);
      far.let_go();
      settle();
      rd(ADDR_STATUS);
      chk(d & 32'h1, 32'h1);
      wr(ADDR_CTRL, 32'h0000_0005);
      rd(ADDR_STATUS);
      chk(d & 32'h1, 32'h0);
      chk({31'h0, pin_oe}, 32'h0);
      $display("test invert and level done");
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_seq();
      t_meter();
      t_out();
      t_gpo();
      t_inv();
      stop_test();
   end
endmodule
`default_nettype wire
